// ==== inc/cis_pkg.sv ====
// Package for the channel interrupt source summary block
package cis_pkg;
    localparam int CIS_NUM_CH = 22;
    localparam logic [11:0] CIS_OFF_LOW = 12'h2c0;
    localparam logic [11:0] CIS_OFF_MID = 12'h300;
    localparam logic [11:0] CIS_OFF_HIGH = 12'h340;
    localparam logic [11:0] CIS_OFF_ZERO = 12'h380;
    localparam logic [11:0] CIS_OFF_IRQ_STAT = 12'h3e0;
    localparam logic [11:0] CIS_OFF_IRQ_MASK = 12'h3e4;
    localparam logic [7:0] CIS_RST_SUMMARY = 8'h00;
    localparam logic [3:0] CIS_RST_IRQ_MASK = 4'h0;
    localparam int CIS_POS_LOW = 0;
    localparam int CIS_POS_MID = 8;
    localparam int CIS_POS_HIGH = 16;
    localparam int CIS_W_HIGH = 5;
    localparam int CIS_POS_ZERO_BIT = 7;
    localparam int CIS_GRP_LOW = 0;
    localparam int CIS_GRP_MID = 1;
    localparam int CIS_GRP_HIGH = 2;
    localparam int CIS_GRP_ZERO = 3;
    localparam int CIS_NUM_GRP = 4;
endpackage : cis_pkg

// ==== core/cis_group_or.sv ====
// Channel summary grouping: slices chan_flags_any into the low, mid, high and zero groups
`timescale 1ns/1ps
module cis_group_or
    import cis_pkg::*;
(
    input wire logic [CIS_NUM_CH-1:0] chan_flags_any,
    output logic [7:0] chan_pending_low_group,
    output logic [7:0] chan_pending_mid_group,
    output logic [4:0] chan_pending_high_group,
    output logic chan_zero_pending
);
    assign chan_zero_pending = chan_flags_any[0];
    assign chan_pending_low_group = chan_flags_any[CIS_POS_LOW+8 -: 8];
    assign chan_pending_mid_group = chan_flags_any[CIS_POS_MID+8 -: 8];
    assign chan_pending_high_group = chan_flags_any[CIS_POS_HIGH+CIS_W_HIGH -: CIS_W_HIGH];
endmodule : cis_group_or

// ==== core/cis_irq_status.sv ====
// Sticky status and mask for group interrupt events
`timescale 1ns/1ps
module cis_irq_status
    import cis_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [CIS_NUM_GRP-1:0] grp_any,
    input wire logic clr_we,
    input wire logic mask_we,
    input wire logic [CIS_NUM_GRP-1:0] wdata,
    output logic [CIS_NUM_GRP-1:0] stat_q,
    output logic [CIS_NUM_GRP-1:0] mask_q,
    output logic irq
);
    logic [CIS_NUM_GRP-1:0] grp_prev_q;
    logic [CIS_NUM_GRP-1:0] rise;

    assign rise = grp_any & ~grp_prev_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            grp_prev_q <= '0;
        end else begin
            grp_prev_q <= grp_any;
        end
    end

    // Set wins over clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~(clr_we ? wdata : '0)) | rise;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= CIS_RST_IRQ_MASK;
        end else if (mask_we) begin
            mask_q <= wdata;
        end
    end

    assign irq = |(stat_q & mask_q);
endmodule : cis_irq_status

// ==== core/cis_channel_irq_summary.sv ====
// Channel interrupt source summary with APB slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module cis_channel_irq_summary
    import cis_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [CIS_NUM_CH-1:0] chan_flags_any,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    // ------------------------------------------------------------
    // Summary bits
    // ------------------------------------------------------------
    logic [7:0] chan_pending_low_group;
    logic [7:0] chan_pending_mid_group;
    logic [4:0] chan_pending_high_group;
    logic chan_zero_pending;
    logic [CIS_NUM_CH-1:0] flags_gated;
    logic rst_seen_q;

    // Reads 0 in the first cycle after reset release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_seen_q <= 1'b0;
        end else begin
            rst_seen_q <= 1'b1;
        end
    end

    assign flags_gated = rst_seen_q ? chan_flags_any : '0;

    cis_group_or u_or (
        .chan_flags_any(flags_gated),
        .chan_pending_low_group(chan_pending_low_group),
        .chan_pending_mid_group(chan_pending_mid_group),
        .chan_pending_high_group(chan_pending_high_group),
        .chan_zero_pending(chan_zero_pending)
    );

    logic [7:0] reg_low;
    logic [7:0] reg_mid;
    logic [7:0] reg_high;
    logic [7:0] reg_zero;

    assign reg_low = chan_pending_low_group;
    assign reg_mid = chan_pending_mid_group;
    assign reg_high = {3'h0, chan_pending_high_group};
    assign reg_zero = {chan_zero_pending, 7'h00};

    // ------------------------------------------------------------
    // Group events and interrupt
    // ------------------------------------------------------------
    logic [CIS_NUM_GRP-1:0] grp_any;
    logic [CIS_NUM_GRP-1:0] stat_q;
    logic [CIS_NUM_GRP-1:0] mask_q;
    logic wr_acc;
    logic clr_we;
    logic mask_we;

    assign grp_any[CIS_GRP_LOW] = |reg_low;
    assign grp_any[CIS_GRP_MID] = |reg_mid;
    assign grp_any[CIS_GRP_HIGH] = |reg_high;
    assign grp_any[CIS_GRP_ZERO] = |reg_zero;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction : hit

    assign wr_acc = psel & penable & pwrite & pstrb[0];
    assign clr_we = wr_acc & hit(paddr, CIS_OFF_IRQ_STAT);
    assign mask_we = wr_acc & hit(paddr, CIS_OFF_IRQ_MASK);

    cis_irq_status u_irq (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .grp_any(grp_any),
        .clr_we(clr_we),
        .mask_we(mask_we),
        .wdata(pwdata[CIS_NUM_GRP-1:0]),
        .stat_q(stat_q),
        .mask_q(mask_q),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    logic mapped;

    assign pready = 1'b1;
    assign mapped = hit(paddr, CIS_OFF_LOW) | hit(paddr, CIS_OFF_MID) | hit(paddr, CIS_OFF_HIGH)
        | hit(paddr, CIS_OFF_ZERO) | hit(paddr, CIS_OFF_IRQ_STAT) | hit(paddr, CIS_OFF_IRQ_MASK);
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            if (hit(paddr, CIS_OFF_LOW)) begin
                prdata = {24'h0, reg_low};
            end else if (hit(paddr, CIS_OFF_MID)) begin
                prdata = {24'h0, reg_mid};
            end else if (hit(paddr, CIS_OFF_HIGH)) begin
                prdata = {24'h0, reg_high};
            end else if (hit(paddr, CIS_OFF_ZERO)) begin
                prdata = {24'h0, reg_zero};
            end else if (hit(paddr, CIS_OFF_IRQ_STAT)) begin
                prdata = {28'h0, stat_q};
            end else if (hit(paddr, CIS_OFF_IRQ_MASK)) begin
                prdata = {28'h0, mask_q};
            end
        end
    end
endmodule : cis_channel_irq_summary

// ==== test/cis_monitor.sv ====
// Assertion checker for the channel summary block
`timescale 1ns/1ps
module cis_mon
    import cis_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [CIS_NUM_CH-1:0] chan_flags_any,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    // ------
    // Checks
    // ------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic [21:0] fl = chan_flags_any;
    wire logic rd = psel && penable && !pwrite;
    AST_LOW: assert property (rd && paddr == CIS_OFF_LOW |-> prdata == {24'h0, fl[8:1]})
        else $error("low group");
    AST_MID: assert property (rd && paddr == CIS_OFF_MID |-> prdata == {24'h0, fl[16:9]})
        else $error("mid group");
    AST_HIGH: assert property (rd && paddr == CIS_OFF_HIGH |-> prdata == {27'h0, fl[21:17]})
        else $error("high group");
    AST_ZERO: assert property (rd && paddr == CIS_OFF_ZERO |-> prdata == {24'h0, fl[0], 7'h0})
        else $error("channel zero");
    AST_RST: assert property (!$past(rst_b) |-> !irq)
        else $error("irq after reset");
    AST_SUMW: assert property (psel && penable && pwrite && paddr == CIS_OFF_LOW |-> !pslverr)
        else $error("summary write error");
    AST_UNM: assert property (rd && paddr == 12'h004 |-> pslverr && prdata == 32'h0)
        else $error("unmapped read");
    cover property (irq);
    cover property (pslverr);
    cover property (rd && paddr == CIS_OFF_LOW && prdata != 32'h0);
endmodule : cis_mon

bind cis_channel_irq_summary cis_mon cis_mon_i (.ref_clk, .rst_b, .chan_flags_any, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .irq);

// ==== test/tb.sv ====
// Self-checking bench for the channel summary block
`timescale 1ns/1ps
module tb;
    import cis_pkg::*;
    logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [21:0] f = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, irq;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [11:0] ad[4] = '{CIS_OFF_LOW, CIS_OFF_MID, CIS_OFF_HIGH, CIS_OFF_ZERO};
    int fail_count = 0, n_tests = 0, seed = 69053, i;
    wire logic [33:0] g = {pslverr, irq, prdata};
    cis_channel_irq_summary cis_channel_irq_summary_i (.ref_clk, .rst_b, .chan_flags_any(f), .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .irq);
    // ----------
    // Procedures
    // ----------
    initial forever #2.5 ref_clk = ~ref_clk;
    task finish_test;
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] x);
        if (!w) q.push_back(x);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge ref_clk);
    endtask : apb
    function automatic logic [31:0] sx(input logic [11:0] a);
        case (a)
            CIS_OFF_LOW: sx = {24'h0, f[8:1]};
            CIS_OFF_MID: sx = {24'h0, f[16:9]};
            CIS_OFF_HIGH: sx = {27'h0, f[21:17]};
            default: sx = {24'h0, f[0], 7'h0};
        endcase
    endfunction : sx
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite) begin
            e = q.pop_front();
            n_tests++;
            if (g !== e) begin
                fail_count++;
                $display("wrong value %0t got %h expected %h", $time, g, e);
            end
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1;
        @(posedge ref_clk);
        for (i = 0; i < 4; i++) apb(0, ad[i], 0, 0);
        apb(0, CIS_OFF_IRQ_MASK, 0, 0);
        for (i = 0; i < 40; i++) begin
            f <= 22'($random(seed));
            @(posedge ref_clk);
            apb(1, ad[i % 4], $random(seed), 0);
            apb(0, ad[i % 4], 0, {2'b0, sx(ad[i % 4])});
        end
        f <= '0;
        @(posedge ref_clk);
        apb(1, CIS_OFF_IRQ_STAT, 32'hf, 0);
        apb(0, CIS_OFF_IRQ_STAT, 0, 0);
        f <= 22'h2;
        @(posedge ref_clk);
        apb(0, CIS_OFF_IRQ_STAT, 0, 34'h1);
        apb(1, CIS_OFF_IRQ_MASK, 32'h1, 0);
        apb(0, CIS_OFF_IRQ_STAT, 0, 34'h100000001);
        apb(1, CIS_OFF_IRQ_STAT, 32'h1, 0);
        apb(0, CIS_OFF_IRQ_MASK, 0, 34'h1);
        apb(0, 12'h004, 0, 34'h200000000);
        finish_test();
    end
    // About twelve times the expected run length
    initial begin
        #20000;
        fail_count++;
        finish_test();
    end
endmodule : tb
